// ===== verification/arbitrary_setpoint_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"

module arbitrary_setpoint_sequencer_test;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        alarm = 1'b0;
   logic        clr = 1'b0;
   logic        use_curr = 1'b0;
   logic [31:0] rdata;
   logic [31:0] r;
   logic [15:0] volt;
   logic [15:0] curr;
   logic [15:0] lvl [0:7];
   logic [3:0]  lcnt;
   logic        on;
   logic        running;
   logic        alm;
   int          miscompares = 0;
   int          samples_checked = 0;
   int          ticks = 0;

   always #5 clk = ~clk;

   // Whole run is about 70000 cycles
   always @(posedge clk) begin
      ticks++;
      if (ticks == 100000) begin
         miscompares++;
         end_sim();
      end
   end

   asq_top dut_u (.CLK_IN(clk), .ARST_N_IN(arst_n), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
      .ALARM_IN(alarm), .RDATA_OUT(rdata), .VOLT_SET_OUT(volt), .CURR_SET_OUT(curr), .OUTPUT_ON_OUT(on),
      .RUNNING_OUT(running), .ALARM_OUT(alm));

   asq_loop_model loop_u (.clk_in(clk), .arst_n_in(arst_n), .use_curr_in(use_curr), .clr_in(clr),
      .act_in(running), .volt_in(volt), .curr_in(curr), .level_out(lvl), .count_out(lcnt));

   task automatic end_sim();
      if (miscompares == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic look(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : look

   // Leading edge wait keeps strobes off the edge that lowered them
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      rd_reg(a, r);
      chk(r, exp);
   endtask : rd_chk

   task automatic set_point(input logic [6:0] n, input logic [15:0] amp, input logic [15:0] frq,
                            input logic [15:0] ang, input logic [15:0] lb, input logic [31:0] dur);
      logic [15:0] f [0:6];
      f = '{amp, amp, frq, frq, ang, lb, lb};
      for (int i = 0; i < 7; i++) wr_reg(`REG_STG_BASE + 8'(i), {16'h0, f[i]});
      wr_reg(`REG_STG_BASE + 8'h07, dur);
      wr_reg(`REG_COMMIT, {25'h0, n});
   endtask : set_point

   task automatic t_regs();
      rd_chk(`REG_FIRST, 32'h1);
      rd_chk(`REG_LAST, 32'h1);
      rd_chk(`REG_CYCLES, 32'h1);
      rd_chk(`REG_TARGET, 32'h0);
      rd_chk(8'h30, 32'h0);
      wr_reg(`REG_FIRST, 32'h2);
      rd_chk(`REG_FIRST, 32'h1);
      wr_reg(`REG_LAST, 32'd100);
      rd_chk(`REG_LAST, 32'h1);
      wr_reg(`REG_LAST, 32'd99);
      wr_reg(`REG_FIRST, 32'd99);
      wr_reg(`REG_FIRST, 32'h0);
      rd_chk(`REG_FIRST, 32'd99);
      wr_reg(`REG_CYCLES, 32'd1000);
      rd_chk(`REG_CYCLES, 32'h1);
      wr_reg(`REG_CYCLES, 32'd999);
      rd_chk(`REG_CYCLES, 32'd999);
   endtask : t_regs

   // Long base duration so that one-LSB sweeps fall under the slope limits
   task automatic t_commit();
      logic [40:0] tc [0:11];
      tc = '{{8'h10, 32'h8000, 1'b1}, {8'h12, 32'd10001, 1'b1}, {8'h12, 32'd10000, 1'b0},
             {8'h14, 32'd360, 1'b1}, {8'h14, 32'd359, 1'b0}, {8'h10, 32'h1001, 1'b1},
             {8'h10, 32'h1000, 1'b0}, {8'h17, 32'h0, 1'b1}, {8'h17, 32'd360000001, 1'b1},
             {8'h13, 32'h1, 1'b1}, {8'h13, 32'd10, 1'b0}, {8'h11, 32'h1, 1'b1}};
      foreach (tc[i]) begin
         set_point(7'd1, 16'h0, 16'h0, 16'h0, 16'h1000, 32'd10001);
         wr_reg(`REG_CTRL, 32'h8);
         wr_reg(tc[i][40:33], tc[i][32:1]);
         wr_reg(`REG_COMMIT, 32'h1);
         rd_reg(`REG_STATUS, r);
         chk({31'h0, r[3]}, {31'h0, tc[i][0]});
      end
   endtask : t_commit

   task automatic t_seq();
      int n;
      n = 0;
      wr_reg(`REG_FIRST, 32'h1);
      wr_reg(`REG_LAST, 32'h2);
      wr_reg(`REG_CYCLES, 32'h2);
      wr_reg(`REG_STATIC_V, 32'h0500);
      wr_reg(`REG_STATIC_I, 32'h0700);
      set_point(7'd1, 16'h0, 16'h0, 16'h0, 16'h1000, 32'h1);
      set_point(7'd2, 16'h0, 16'h0, 16'h0, 16'h2000, 32'h1);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      wr_reg(`REG_CTRL, 32'h1);
      look(3);
      chk({30'h0, running, on}, 32'h3);
      chk({volt, curr}, 32'h10000700);
      while (running === 1'b1 && n < 50000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, n >= 39995 && n <= 40010}, 32'h1);
      chk({lvl[0], lvl[1]}, 32'h10002000);
      chk({lvl[2], lvl[3]}, 32'h10002000);
      chk({28'h0, lcnt}, 32'h4);
      look(2);
      chk({16'h0, volt}, 32'h0500);
   endtask : t_seq

   task automatic t_halt();
      wr_reg(`REG_TARGET, 32'h1);
      use_curr <= 1'b1;
      wr_reg(`REG_CYCLES, 32'h10001);
      wr_reg(`REG_LAST, 32'h1);
      set_point(7'd1, 16'h0, 16'h0, 16'h0, 16'h1000, 32'h1);
      wr_reg(`REG_CTRL, 32'h1);
      look(3);
      chk({volt, curr}, 32'h05001000);
      wr_reg(`REG_TARGET, 32'h0);
      rd_chk(`REG_TARGET, 32'h1);
      look(10100);
      chk({31'h0, running}, 32'h1);
      wr_reg(`REG_CTRL, 32'h2);
      look(2);
      chk({14'h0, running, on, curr}, 32'h00010700);
      wr_reg(`REG_CTRL, 32'h1);
      look(3);
      wr_reg(`REG_CTRL, 32'h4);
      look(2);
      chk({30'h0, running, on}, 32'h0);
      wr_reg(`REG_CTRL, 32'h1);
      look(3);
      @(posedge clk);
      alarm <= 1'b1;
      look(6);
      chk({29'h0, running, on, alm}, 32'h1);
      wr_reg(`REG_CTRL, 32'h1);
      look(3);
      chk({31'h0, running}, 32'h0);
      @(posedge clk);
      alarm <= 1'b0;
      look(4);
      wr_reg(`REG_CTRL, 32'h8);
      look(1);
      chk({31'h0, alm}, 32'h0);
      wr_reg(`REG_TARGET, 32'h0);
      use_curr <= 1'b0;
   endtask : t_halt

   // Fifty ticks at 1 kHz is an eighteen degree step, far from a zero crossing
   task automatic t_sine();
      logic [15:0] ang [0:2];
      logic [15:0] frq [0:2];
      ang = '{16'd0, 16'd180, 16'd0};
      frq = '{16'd1000, 16'd1000, 16'd0};
      wr_reg(`REG_CYCLES, 32'h1);
      for (int i = 0; i < 3; i++) begin
         set_point(7'd1, 16'h1000, frq[i], ang[i], 16'h4000, 32'h1);
         wr_reg(`REG_CTRL, 32'h1);
         look(5002);
         if (frq[i] == 16'd0) chk({16'h0, volt}, 32'h4000);
         else chk({31'h0, volt > 16'h4000}, {31'h0, ang[i] == 16'd0});
         wr_reg(`REG_CTRL, 32'h2);
      end
      // Ramp 0x1000 to 0x3000, looked at near half time
      set_point(7'd1, 16'h0, 16'h0, 16'h0, 16'h1000, 32'h1);
      wr_reg(`REG_STG_BASE + 8'h06, 32'h3000);
      wr_reg(`REG_COMMIT, 32'h1);
      wr_reg(`REG_CTRL, 32'h1);
      look(5002);
      chk({31'h0, volt > 16'h1f00 && volt < 16'h2100}, 32'h1);
      wr_reg(`REG_CTRL, 32'h2);
   endtask : t_sine

   initial begin
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      t_regs();
      t_commit();
      t_seq();
      t_halt();
      t_sine();
      end_sim();
   end
endmodule : arbitrary_setpoint_sequencer_test

`default_nettype wire

// ===== verification/asq_loop_model.sv
`timescale 1ns/1ps
`default_nettype none

module asq_loop_model (
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        use_curr_in,
   input  wire logic        clr_in,
   input  wire logic        act_in,
   input  wire logic [15:0] volt_in,
   input  wire logic [15:0] curr_in,
   output logic      [15:0] level_out [0:7],
   output logic      [3:0]  count_out
);
   logic [15:0] want;
   logic [2:0]  prev;

   assign want = use_curr_in ? curr_in : volt_in;
   assign prev = 3'(count_out - 4'h1);

   // Loop follows one set value only; logs each new level, stops at eight
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_out <= 4'h0;
      end else if (clr_in) begin
         count_out <= 4'h0;
      end else if (act_in && count_out < 4'h8 && (count_out == 4'h0 || want != level_out[prev])) begin
         level_out[count_out[2:0]] <= want;
         count_out                 <= count_out + 4'h1;
      end
   end
endmodule : asq_loop_model

`default_nettype wire

// ===== verilog/asq_defs.svh
`ifndef ASQ_DEFS_SVH
`define ASQ_DEFS_SVH

// Clock and timing
`define CLK_PERIOD_NS   32'd10
`define POINT_UNIT_NS   32'd100000
`define TICK_NS         32'd1000
`define TICK_CYC        7'(`TICK_NS / `CLK_PERIOD_NS)
`define TICKS_PER_UNIT  36'(`POINT_UNIT_NS / `TICK_NS)
`define UNITS_PER_S     40'd10000
`define TICK_RATE_HZ    64'd1000000
`define PHASE_PER_HZ    32'(64'h1_0000_0000 / `TICK_RATE_HZ)
// Rounded up so that 180 degrees lands inside the negative half
`define PHASE_PER_DEG   32'((64'h1_0000_0000 + 64'd359) / 64'd360)
`define DIV_BITS        5'd16
`define DIV_DONE        7'd17

// Limits
`define POINT_COUNT     7'd99
`define NOMINAL         16'hffff
`define AMP_MAX         16'h7fff
`define FREQ_MAX        16'd10000
`define ANGLE_MAX       16'd359
`define DUR_MIN         32'd1
`define DUR_MAX         32'd360000000
`define DF_SCALE        40'd100000
`define DF_MIN_X10      40'd93
`define CYCLES_MAX      10'd999

// Register offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h01
`define REG_TARGET      8'h02
`define REG_FIRST       8'h03
`define REG_LAST        8'h04
`define REG_CYCLES      8'h05
`define REG_STATIC_V    8'h06
`define REG_STATIC_I    8'h07
`define REG_COMMIT      8'h08
`define REG_STG_BASE    8'h10

// Control bits, and the infinite-repeat bit of REG_CYCLES
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_OFF        2
`define CTRL_CLEAR      3
`define CYC_INFINITE    16

// Reset values
`define RST_FIRST       7'd1
`define RST_LAST        7'd1
`define RST_CYCLES      10'd1

`endif

// ===== verilog/asq_pkg.sv
`default_nettype none

package asq_pkg;

   typedef enum logic [1:0] {
      ASQ_IDLE = 2'b00,
      ASQ_LOAD = 2'b01,
      ASQ_RUN  = 2'b10
   } asq_state_e;

endpackage : asq_pkg

`default_nettype wire

// ===== verilog/asq_top.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "asq_defs.svh"

module asq_top
   import asq_pkg::*;
(
   input  wire logic        CLK_IN,
   input  wire logic        ARST_N_IN,
   input  wire logic [7:0]  ADDR_IN,
   input  wire logic [31:0] WDATA_IN,
   input  wire logic        WR_IN,
   input  wire logic        RD_IN,
   input  wire logic        ALARM_IN,
   output logic      [31:0] RDATA_OUT,
   output logic      [15:0] VOLT_SET_OUT,
   output logic      [15:0] CURR_SET_OUT,
   output logic             OUTPUT_ON_OUT,
   output logic             RUNNING_OUT,
   output logic             ALARM_OUT
);

   function automatic logic [15:0] interp(input logic [15:0] b, input logic [15:0] f, input logic [15:0] fr);
      logic signed [16:0] d;
      logic signed [33:0] p;
      d = $signed({1'b0, f}) - $signed({1'b0, b});
      p = d * $signed({1'b0, fr});
      interp = b + p[31:16];
   endfunction : interp

   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      absdiff = (a > b) ? a - b : b - a;
   endfunction : absdiff

   asq_state_e        state;
   logic              alarm_meta;
   logic              alarm_sync;
   logic              alarm_flag;
   logic              reject;
   logic              output_on;
   logic              target_curr;
   logic [6:0]        first_pt;
   logic [6:0]        last_pt;
   logic [9:0]        cycles;
   logic              infinite;
   logic [15:0]       static_volt;
   logic [15:0]       static_curr;
   logic [15:0]       stg [0:6];
   logic [31:0]       stg_dur;
   // Point store, one entry per field
   logic [15:0]       mem_amp_b   [0:98];
   logic [15:0]       mem_amp_f   [0:98];
   logic [15:0]       mem_freq_b  [0:98];
   logic [15:0]       mem_freq_f  [0:98];
   logic [8:0]        mem_angle   [0:98];
   logic [15:0]       mem_level_b [0:98];
   logic [15:0]       mem_level_f [0:98];
   logic [31:0]       mem_dur     [0:98];
   logic [6:0]        cur_idx;
   logic [9:0]        cycles_done;
   logic [6:0]        tick_cnt;
   logic [35:0]       elapsed;
   logic [35:0]       total;
   logic [31:0]       phase;
   logic [31:0]       phase_inc;
   logic [36:0]       div_rem;
   logic [36:0]       div_shift;
   logic [15:0]       div_q;
   logic [4:0]        div_cnt;
   logic [15:0]       wave;
   logic              stage_ok;
   logic              wr_ctrl;
   logic              cmd_start;
   logic              cmd_halt;
   logic              tick_end;
   logic              point_end;
   logic [6:0]        ptr;
   logic [6:0]        commit_idx;
   logic              fzero;
   logic [15:0]       amp_now;
   logic [15:0]       level_now;
   logic [15:0]       freq_now;
   logic [15:0]       sine_mag;
   logic [31:0]       sine_prod;
   logic [31:0]       ac_prod;
   logic [15:0]       next_wave;

   assign ptr        = cur_idx - 7'd1;
   assign commit_idx = WDATA_IN[6:0];
   assign wr_ctrl    = WR_IN && (ADDR_IN == `REG_CTRL);
   assign cmd_start  = wr_ctrl && WDATA_IN[`CTRL_START] && !alarm_sync;
   assign cmd_halt   = wr_ctrl && (WDATA_IN[`CTRL_STOP] || WDATA_IN[`CTRL_OFF]);
   assign tick_end   = (state == ASQ_RUN) && (tick_cnt == `TICK_CYC - 7'd1);
   assign point_end  = tick_end && (elapsed == total - 36'd1);

   // Alarm pin synchroniser
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         alarm_meta <= 1'b0;
         alarm_sync <= 1'b0;
      end else begin
         alarm_meta <= ALARM_IN;
         alarm_sync <= alarm_meta;
      end
   end

   // Whole staged point checked at commit; a refused set leaves the store untouched
   always_comb begin
      logic [15:0] da;
      logic [15:0] df;
      da = absdiff(stg[0], stg[1]);
      df = absdiff(stg[2], stg[3]);
      stage_ok = (commit_idx >= 7'd1) && (commit_idx <= `POINT_COUNT);
      if (stg[0] > `AMP_MAX || stg[1] > `AMP_MAX) begin
         stage_ok = 1'b0;
      end
      if (stg[2] > `FREQ_MAX || stg[3] > `FREQ_MAX) begin
         stage_ok = 1'b0;
      end
      if (stg[4] > `ANGLE_MAX) begin
         stage_ok = 1'b0;
      end
      if (stg[5] < stg[0] || stg[5] > `NOMINAL - stg[0] || stg[6] < stg[1] || stg[6] > `NOMINAL - stg[1]) begin
         stage_ok = 1'b0;
      end
      if (stg_dur < `DUR_MIN || stg_dur > `DUR_MAX) begin
         stage_ok = 1'b0;
      end
      if (df != 16'h0 && 40'(df) * `DF_SCALE < `DF_MIN_X10 * 40'(stg_dur)) begin
         stage_ok = 1'b0;
      end
      if (da != 16'h0 && 40'(da) * `UNITS_PER_S < 40'(stg_dur)) begin
         stage_ok = 1'b0;
      end
   end

   // Software-written configuration
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         target_curr <= 1'b0;
         first_pt    <= `RST_FIRST;
         last_pt     <= `RST_LAST;
         cycles      <= `RST_CYCLES;
         infinite    <= 1'b0;
         static_volt <= 16'h0;
         static_curr <= 16'h0;
         stg_dur     <= `DUR_MIN;
         for (int i = 0; i < 7; i++) begin
            stg[i] <= 16'h0;
         end
      end else if (WR_IN) begin
         if (ADDR_IN == `REG_TARGET) begin
            if (state == ASQ_IDLE) begin
               target_curr <= WDATA_IN[0];
            end
         end else if (ADDR_IN == `REG_FIRST) begin
            if (WDATA_IN[6:0] >= 7'd1 && WDATA_IN[6:0] <= last_pt) begin
               first_pt <= WDATA_IN[6:0];
            end
         end else if (ADDR_IN == `REG_LAST) begin
            if (WDATA_IN[6:0] >= first_pt && WDATA_IN[6:0] <= `POINT_COUNT) begin
               last_pt <= WDATA_IN[6:0];
            end
         end else if (ADDR_IN == `REG_CYCLES) begin
            infinite <= WDATA_IN[`CYC_INFINITE];
            if (WDATA_IN[9:0] >= 10'd1 && WDATA_IN[9:0] <= `CYCLES_MAX) begin
               cycles <= WDATA_IN[9:0];
            end
         end else if (ADDR_IN == `REG_STATIC_V) begin
            static_volt <= WDATA_IN[15:0];
         end else if (ADDR_IN == `REG_STATIC_I) begin
            static_curr <= WDATA_IN[15:0];
         end else if (ADDR_IN >= `REG_STG_BASE && ADDR_IN < `REG_STG_BASE + 8'd7) begin
            stg[3'(ADDR_IN - `REG_STG_BASE)] <= WDATA_IN[15:0];
         end else if (ADDR_IN == `REG_STG_BASE + 8'd7) begin
            stg_dur <= WDATA_IN;
         end
      end
   end

   // Point store, no reset: contents are software's
   always_ff @(posedge CLK_IN) begin
      if (WR_IN && ADDR_IN == `REG_COMMIT && stage_ok) begin
         mem_amp_b[commit_idx - 7'd1]   <= stg[0];
         mem_amp_f[commit_idx - 7'd1]   <= stg[1];
         mem_freq_b[commit_idx - 7'd1]  <= stg[2];
         mem_freq_f[commit_idx - 7'd1]  <= stg[3];
         mem_angle[commit_idx - 7'd1]   <= stg[4][8:0];
         mem_level_b[commit_idx - 7'd1] <= stg[5];
         mem_level_f[commit_idx - 7'd1] <= stg[6];
         mem_dur[commit_idx - 7'd1]     <= stg_dur;
      end
   end

   // Sticky flags; a new event beats a clear in the same cycle
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         alarm_flag <= 1'b0;
         reject     <= 1'b0;
      end else begin
         if (alarm_sync) begin
            alarm_flag <= 1'b1;
         end else if (wr_ctrl && WDATA_IN[`CTRL_CLEAR]) begin
            alarm_flag <= 1'b0;
         end
         if (WR_IN && ADDR_IN == `REG_COMMIT && !stage_ok) begin
            reject <= 1'b1;
         end else if (wr_ctrl && WDATA_IN[`CTRL_CLEAR]) begin
            reject <= 1'b0;
         end
      end
   end

   // Output switch
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         output_on <= 1'b0;
      end else if (alarm_sync) begin
         output_on <= 1'b0;
      end else if (wr_ctrl && WDATA_IN[`CTRL_OFF]) begin
         output_on <= 1'b0;
      end else if (cmd_start) begin
         output_on <= 1'b1;
      end
   end

   // Sequencer
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         state       <= ASQ_IDLE;
         cur_idx     <= `RST_FIRST;
         cycles_done <= 10'd0;
         tick_cnt    <= 7'd0;
         elapsed     <= 36'd0;
         total       <= 36'd1;
      end else if (alarm_sync || cmd_halt) begin
         state <= ASQ_IDLE;
      end else begin
         case (state)
            ASQ_IDLE: begin
               if (cmd_start) begin
                  cur_idx     <= first_pt;
                  cycles_done <= 10'd0;
                  state       <= ASQ_LOAD;
               end
            end
            ASQ_LOAD: begin
               total    <= 36'(mem_dur[ptr]) * `TICKS_PER_UNIT;
               elapsed  <= 36'd0;
               tick_cnt <= 7'd0;
               state    <= ASQ_RUN;
            end
            ASQ_RUN: begin
               if (tick_end) begin
                  tick_cnt <= 7'd0;
                  elapsed  <= elapsed + 36'd1;
               end else begin
                  tick_cnt <= tick_cnt + 7'd1;
               end
               if (point_end) begin
                  if (cur_idx < last_pt) begin
                     cur_idx <= cur_idx + 7'd1;
                     state   <= ASQ_LOAD;
                  end else if (infinite || cycles_done + 10'd1 < cycles) begin
                     cycles_done <= cycles_done + 10'd1;
                     cur_idx     <= first_pt;
                     state       <= ASQ_LOAD;
                  end else begin
                     state <= ASQ_IDLE;
                  end
               end
            end
            default: begin
               state <= ASQ_IDLE;
            end
         endcase
      end
   end

   // Elapsed fraction of the point, one 16-step division per tick
   assign div_shift = {div_rem[35:0], 1'b0};

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         div_rem <= 37'd0;
         div_q   <= 16'h0;
         div_cnt <= 5'd0;
      end else if (state == ASQ_RUN && tick_cnt == 7'd0) begin
         div_rem <= {1'b0, elapsed};
         div_q   <= 16'h0;
         div_cnt <= `DIV_BITS;
      end else if (div_cnt != 5'd0) begin
         div_cnt <= div_cnt - 5'd1;
         if (div_shift >= {1'b0, total}) begin
            div_rem <= div_shift - {1'b0, total};
            div_q   <= {div_q[14:0], 1'b1};
         end else begin
            div_rem <= div_shift;
            div_q   <= {div_q[14:0], 1'b0};
         end
      end
   end

   // Waveform: ramp plus parabolic sine, sign from phase MSB
   assign fzero     = (mem_freq_b[ptr] == 16'h0) && (mem_freq_f[ptr] == 16'h0);
   assign amp_now   = interp(mem_amp_b[ptr], mem_amp_f[ptr], div_q);
   assign level_now = interp(mem_level_b[ptr], mem_level_f[ptr], div_q);
   assign freq_now  = interp(mem_freq_b[ptr], mem_freq_f[ptr], div_q);
   assign sine_prod = {17'h0, phase[30:16]} * (32'h8000 - {17'h0, phase[30:16]});
   assign sine_mag  = sine_prod[28] ? 16'h7fff : sine_prod[28:13];
   assign ac_prod   = amp_now * sine_mag;

   always_comb begin
      if (fzero) begin
         next_wave = level_now;
      end else if (phase[31]) begin
         next_wave = level_now - ac_prod[30:15];
      end else begin
         next_wave = level_now + ac_prod[30:15];
      end
   end

   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         phase     <= 32'h0;
         phase_inc <= 32'h0;
         wave      <= 16'h0;
      end else if (state == ASQ_LOAD) begin
         // Each point and each repetition starts from its own start values
         phase     <= 32'(mem_angle[ptr]) * `PHASE_PER_DEG;
         phase_inc <= 32'(mem_freq_b[ptr]) * `PHASE_PER_HZ;
         wave      <= mem_level_b[ptr];
      end else if (state == ASQ_IDLE) begin
         // Preload so the first running cycle never shows a stale level
         wave <= mem_level_b[first_pt - 7'd1];
      end else if (state == ASQ_RUN) begin
         if (tick_end) begin
            phase <= phase + phase_inc;
         end
         if (tick_cnt == `DIV_DONE) begin
            wave      <= next_wave;
            phase_inc <= 32'(freq_now) * `PHASE_PER_HZ;
         end
      end
   end

   // Set values and status pins
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         VOLT_SET_OUT  <= 16'h0;
         CURR_SET_OUT  <= 16'h0;
         OUTPUT_ON_OUT <= 1'b0;
         RUNNING_OUT   <= 1'b0;
         ALARM_OUT     <= 1'b0;
      end else begin
         VOLT_SET_OUT  <= (state != ASQ_IDLE && !target_curr) ? wave : static_volt;
         CURR_SET_OUT  <= (state != ASQ_IDLE && target_curr) ? wave : static_curr;
         OUTPUT_ON_OUT <= output_on;
         RUNNING_OUT   <= (state != ASQ_IDLE);
         ALARM_OUT     <= alarm_flag;
      end
   end

   // Read port, data one cycle after the strobe
   always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         RDATA_OUT <= 32'h0;
      end else if (!RD_IN) begin
         RDATA_OUT <= 32'h0;
      end else if (ADDR_IN == `REG_STATUS) begin
         RDATA_OUT <= {6'h0, cycles_done, 1'b0, cur_idx, 4'h0, reject, alarm_flag, output_on, state != ASQ_IDLE};
      end else if (ADDR_IN == `REG_TARGET) begin
         RDATA_OUT <= {31'h0, target_curr};
      end else if (ADDR_IN == `REG_FIRST) begin
         RDATA_OUT <= {25'h0, first_pt};
      end else if (ADDR_IN == `REG_LAST) begin
         RDATA_OUT <= {25'h0, last_pt};
      end else if (ADDR_IN == `REG_CYCLES) begin
         RDATA_OUT <= {15'h0, infinite, 6'h0, cycles};
      end else if (ADDR_IN == `REG_STATIC_V) begin
         RDATA_OUT <= {16'h0, static_volt};
      end else if (ADDR_IN == `REG_STATIC_I) begin
         RDATA_OUT <= {16'h0, static_curr};
      end else if (ADDR_IN >= `REG_STG_BASE && ADDR_IN < `REG_STG_BASE + 8'd7) begin
         RDATA_OUT <= {16'h0, stg[3'(ADDR_IN - `REG_STG_BASE)]};
      end else if (ADDR_IN == `REG_STG_BASE + 8'd7) begin
         RDATA_OUT <= stg_dur;
      end else begin
         RDATA_OUT <= 32'h0;
      end
   end

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!ARST_N_IN);

   a_alarm_halts: assert property (alarm_sync |=> state == ASQ_IDLE && !output_on ##1 !OUTPUT_ON_OUT && ALARM_OUT)
      else $error("alarm did not halt and switch off");
   a_stop_keeps_on: assert property (wr_ctrl && WDATA_IN[`CTRL_STOP] && !WDATA_IN[`CTRL_OFF] && !alarm_sync && output_on
      |=> state == ASQ_IDLE && output_on)
      else $error("stop changed output or kept running");
   a_off_halts: assert property (wr_ctrl && WDATA_IN[`CTRL_OFF] |=> state == ASQ_IDLE && !output_on)
      else $error("off did not halt and switch off");
   a_point_order: assert property (point_end && cur_idx < last_pt && !alarm_sync && !cmd_halt
      |=> state == ASQ_LOAD && cur_idx == $past(cur_idx) + 7'd1)
      else $error("points not taken in ascending order");
   a_block_bounds: assert property (state == ASQ_RUN |-> cur_idx >= first_pt && cur_idx <= last_pt)
      else $error("point outside block");
   a_cycle_count: assert property (state != ASQ_IDLE && !infinite |-> cycles_done < cycles)
      else $error("repeat count exceeded");
   a_dc_only: assert property (state == ASQ_RUN && tick_cnt == `DIV_DONE && fzero |=> wave == $past(level_now))
      else $error("sine present with zero frequencies");
   a_target_only: assert property (RUNNING_OUT && !target_curr && $stable(target_curr) |-> CURR_SET_OUT == $past(static_curr))
      else $error("non-target set value moved");
   a_phase_start: assert property (state == ASQ_LOAD |=> phase == 32'($past(mem_angle[ptr])) * `PHASE_PER_DEG)
      else $error("start phase not applied");
   a_refuse_keep: assert property (WR_IN && ADDR_IN == `REG_COMMIT && !stage_ok |=> reject)
      else $error("refused point not flagged");

   c_run_start: cover property (cmd_start ##2 state == ASQ_RUN);
   c_repeat: cover property (point_end && cur_idx == last_pt && state == ASQ_RUN ##1 state == ASQ_LOAD);
   c_alarm: cover property (state == ASQ_RUN && alarm_sync);
   c_refused: cover property (WR_IN && ADDR_IN == `REG_COMMIT && !stage_ok);

endmodule : asq_top

`default_nettype wire
